/* dv/ext_pad_model.sv */
/*
  External circuitry on the port pins: resolves each wire from the pad
  driver, the weak pullup and an optional external source.
  Assumes the testbench never drives a pin that the block drives.
*/
`timescale 1ns/1ps
module ext_pad_model (
  // Clock
  input  wire logic        clock_i,
  // Block side
  input  wire logic [15:0] drv_i,
  input  wire logic [15:0] drv_en_i,
  input  wire logic [15:0] pull_i,
  // External sources
  input  wire logic [15:0] ext_val_i,
  input  wire logic [15:0] ext_en_i,
  // Resolved wire
  output logic      [15:0] level_o
);
  logic [15:0] last = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Floating pin toggles so a held value can never pass for a real level
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      level_o[p] = drv_en_i[p] ? drv_i[p] : ext_en_i[p] ? ext_val_i[p] :
                   pull_i[p] ? 1'b1 : ~last[p];
    end
  end

  always @(posedge clock_i) begin
    last <= level_o;
  end
endmodule

/* dv/tb_priority_crossbar_port_mux.sv */
/*
  Self-checking testbench for the priority crossbar port mux.
  Assumes the one-cycle register port and the pad model beside it.
*/
`timescale 1ns/1ps
module tb_priority_crossbar_port_mux;
  import pin_mux_pkg::*;

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [7:0]        rdata;
  logic [10:0]       p_out = 11'h5b4;
  logic [10:0]       p_oe = 11'h7fd;
  logic [10:0]       p_in;
  logic [15:0]       pad_lvl;
  logic [15:0]       pad_val;
  logic [15:0]       pad_oe;
  logic [15:0]       pad_pu;
  logic [15:0]       pad_rx;
  logic [15:0]       ext_val = 16'h0000;
  logic [15:0]       ext_en = 16'h8000;
  int                failures = 0;
  int                check_count = 0;
  int                cycles = 0;

  always #4 clk = ~clk;

  priority_crossbar_port_mux DUT (
    .clock_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .periph_out_i(p_out),
    .periph_oe_i(p_oe), .periph_in_o(p_in), .pad_in_i(pad_lvl),
    .pad_o(pad_val), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu),
    .pad_rx_en_o(pad_rx)
  );

  ext_pad_model pads (
    .clock_i(clk), .drv_i(pad_val), .drv_en_i(pad_oe), .pull_i(pad_pu),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pad_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Run should need about 125 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(rdata, exp);
  endtask

  // Pads follow a write one edge later; pad reads lag by three
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pins(input logic [15:0] oe, input logic [15:0] o,
                      input logic [15:0] pu);
    chk_pin(pad_oe, oe);
    chk_pin(pad_val, o);
    chk_pin(pad_pu, pu);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle(6);
    chk_pin(pad_rx, 16'hffff);
    pins(16'h0000, 16'h0000, 16'hffff);
    rd_chk(OFF_ROUTE_LOW, 8'h00);
    rd_chk(OFF_ROUTE_HIGH, 8'h00);
    rd_chk(OFF_IN_MODE0, 8'hff);
    rd_chk(OFF_LATCH1, 8'h7f);
    rd_chk(OFF_LATCH0, 8'hff);
    $display("test reset done");

    wr_reg(OFF_ROUTE_LOW, 8'hff);
    rd_chk(OFF_ROUTE_LOW, 8'h3f);
    rd_chk(8'h10, 8'h00);
    wr_reg(OFF_LATCH0, 8'h00);
    settle(3);
    chk_pin(pad_oe, 16'h0000);
    wr_reg(OFF_LATCH0, 8'hff);
    $display("test crossbar off done");

    // Software order: output modes, routes, then enable
    wr_reg(OFF_OUT_MODE0, 8'hff);
    wr_reg(OFF_OUT_MODE1, 8'hff);
    wr_reg(OFF_ROUTE_LOW, 8'h07);
    ext_en <= 16'h0020;
    wr_reg(OFF_ROUTE_HIGH, 8'h40);
    rd_chk(OFF_ROUTE_HIGH, 8'h40);
    settle(5);
    pins(16'hff9f, 16'hff85, 16'h0040);
    chk_pin({5'h00, p_in}, 16'h0094);
    ext_val <= 16'h0020;
    settle(5);
    chk_pin({5'h00, p_in}, 16'h0096);
    wr_reg(OFF_LATCH1, 8'h0f);
    settle(3);
    chk_pin(pad_val, 16'h0f85);
    wr_reg(OFF_LATCH1, 8'hff);
    $display("test three wire done");

    wr_reg(OFF_SPI_MODE, 8'h01);
    settle(3);
    pins(16'hff5f, 16'hff0d, 16'h0080);
    wr_reg(OFF_SKIP0, 8'h03);
    settle(3);
    pins(16'hfddf, 16'hfcc7, 16'h0200);
    rd_chk(OFF_SKIP0, 8'h03);
    rd_chk(OFF_SPI_MODE, 8'h01);
    wr_reg(OFF_ROUTE_LOW, 8'h3f);
    settle(3);
    pins(16'hfddf, 16'hf4c7, 16'h0200);
    $display("test skip and routes done");

    wr_reg(OFF_OUT_MODE0, 8'h00);
    wr_reg(OFF_OUT_MODE1, 8'h00);
    wr_reg(OFF_SKIP0, 8'h00);
    wr_reg(OFF_SPI_MODE, 8'h00);
    wr_reg(OFF_ROUTE_LOW, 8'h07);
    settle(3);
    pins(16'h001a, 16'h0000, 16'hffe5);
    // Analog pin skipped first so no route lands on it
    wr_reg(OFF_SKIP0, 8'h01);
    wr_reg(OFF_IN_MODE0, 8'hfe);
    settle(3);
    chk_pin(pad_rx, 16'hfffe);
    chk_pin((pad_oe | pad_pu) & 16'h0001, 16'h0000);
    rd_chk(OFF_IN_MODE0, 8'hfe);
    rd_chk(OFF_OUT_MODE1, 8'h00);
    $display("test open drain done");

    wr_reg(OFF_ROUTE_HIGH, 8'hc4);
    rd_chk(OFF_ROUTE_HIGH, 8'hc0);
    settle(3);
    chk_pin(pad_pu, 16'h0000);
    wr_reg(OFF_ROUTE_HIGH, 8'h00);
    settle(3);
    chk_pin(pad_oe, 16'h0000);
    $display("test pullup and disable done");

    // Frozen block must drop a write that would enable it
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(OFF_ROUTE_HIGH, 8'hc0);
    settle(3);
    chk_pin(pad_oe, 16'h0000);
    chk_pin(pad_pu, 16'hfffe);
    @(posedge clk);
    ce <= 1'b1;
    rd_chk(OFF_ROUTE_HIGH, 8'h00);
    $display("test clock enable done");
    stop_test();
  end
endmodule

/* include/pin_mux_pkg.sv */
/*
  Constants for the priority crossbar port mux: register offsets, field
  positions, reset values and the order in which routed signals claim pins.
  Assumes an 8-bit register port with 8-bit offsets.
*/
package pin_mux_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_PINS = 16;
  localparam int NUM_SIG = 11;

  // Register offsets
  localparam logic [7:0] OFF_ROUTE_LOW = 8'he1;
  localparam logic [7:0] OFF_ROUTE_HIGH = 8'he2;
  localparam logic [7:0] OFF_LATCH0 = 8'ha0;
  localparam logic [7:0] OFF_LATCH1 = 8'ha1;
  localparam logic [7:0] OFF_IN_MODE0 = 8'ha2;
  localparam logic [7:0] OFF_IN_MODE1 = 8'ha3;
  localparam logic [7:0] OFF_OUT_MODE0 = 8'ha4;
  localparam logic [7:0] OFF_OUT_MODE1 = 8'ha5;
  localparam logic [7:0] OFF_SKIP0 = 8'ha6;
  localparam logic [7:0] OFF_SKIP1 = 8'ha7;
  localparam logic [7:0] OFF_SPI_MODE = 8'ha8;

  // Route enable low fields
  localparam int RL_UART = 0;
  localparam int RL_SPI = 1;
  localparam int RL_SMBUS = 2;
  localparam int RL_SYSCLK = 3;
  localparam int RL_CMP_SYNC = 4;
  localparam int RL_CMP_ASYNC = 5;
  localparam logic [7:0] ROUTE_LOW_MASK = 8'h3f;

  // Route enable high fields
  localparam int RH_XBAR_EN = 6;
  localparam int RH_PULLUP_DIS = 7;
  localparam logic [7:0] ROUTE_HIGH_MASK = 8'hfb;

  // Slave-select mode field width
  localparam int SPI_MODE_W = 2;

  // Reset values
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [15:0] RST_IN_MODE = 16'hffff;
  localparam logic [15:0] RST_OUT_MODE = 16'h0000;
  localparam logic [15:0] RST_SKIP = 16'h0000;
  localparam logic [15:0] RST_LATCH = 16'hffff;
  localparam logic [1:0] RST_SPI_MODE = 2'h0;

  // Fixed serial pins
  localparam int PIN_UART_TX = 4;
  localparam int PIN_UART_RX = 5;

  // Signal index, in claim priority
  localparam int SIG_UART_TX = 0;
  localparam int SIG_UART_RX = 1;
  localparam int SIG_SPI_SCK = 2;
  localparam int SIG_SPI_MISO = 3;
  localparam int SIG_SPI_MOSI = 4;
  localparam int SIG_SPI_SEL = 5;
  localparam int SIG_SMB_SDA = 6;
  localparam int SIG_SMB_SCL = 7;
  localparam int SIG_CMP_SYNC = 8;
  localparam int SIG_CMP_ASYNC = 9;
  localparam int SIG_SYSCLK = 10;
  localparam int FIRST_CHAINED = SIG_SPI_SCK;

  localparam int SPI_PINS_3W = 3;
  localparam int SPI_PINS_4W = 4;

endpackage

/* src/pin_claim.sv */
/*
  One claim stage of the crossbar: takes the lowest pin not yet taken.
  Assumes the caller chains stages in priority order.
*/
`timescale 1ns/1ps
module pin_claim #(
  parameter int WIDTH = 16
) (
  // Claim chain
  input  wire logic [WIDTH-1:0] taken_i,
  input  wire logic             req_i,
  output logic      [WIDTH-1:0] grant_o,
  output logic      [WIDTH-1:0] taken_o
);

  logic [WIDTH-1:0] taken_inc;
  logic [WIDTH-1:0] lowest_free;

  // Lowest zero bit; all taken gives no grant
  assign taken_inc = taken_i + WIDTH'(1);
  assign lowest_free = ~taken_i & taken_inc;
  assign grant_o = req_i ? lowest_free : '0;
  assign taken_o = taken_i | grant_o;

endmodule

/* src/priority_crossbar_port_mux.sv */
/*
  Priority crossbar port mux: routes serial, comparator and clock signals
  onto port pins, applies input mode, driver type and weak pullups.
  Assumes a one-cycle register port and pads outside that resolve the wire
  from output, output enable and pullup.
*/
// Operation
// - SMBus claims data and clock pins together
// - UART transmit pin 4, receive pin 5
// - Unclaimed pins serve as plain port I/O
// - SPI takes three or four pins by mode
// - Analog pin: pullup, driver, receiver all off
// - Input mode 1 digital; resets digital
// - Driver type set by output mode, except SMBus pins
// - SMBus pins always open-drain
// - Pullup disable bit low: open-drain pins pulled
// - No pullup on pin driving low
// - Crossbar off: all pins input, routes ignored
// - Crossbar off: every output driver disabled
// - Enable bit set activates current routing
// - Route low bits 7:6 read zero
// - Route low bits select each function
// - Each resource except UART takes lowest free pin
// - Skipped pins treated as already taken; fixed UART pins ignore skip
// - Route high: bit7 pullup off, bit6 enable
// - Digital pin read returns pad level
`timescale 1ns/1ps
module priority_crossbar_port_mux
  import pin_mux_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  // Clock, reset, enable
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rdata_o,
  // Peripheral side
  input  wire logic [NUM_SIG-1:0]  periph_out_i,
  input  wire logic [NUM_SIG-1:0]  periph_oe_i,
  output logic      [NUM_SIG-1:0]  periph_in_o,
  // Pads
  input  wire logic [PINS-1:0]     pad_in_i,
  output logic      [PINS-1:0]     pad_o,
  output logic      [PINS-1:0]     pad_oe_o,
  output logic      [PINS-1:0]     pad_pullup_o,
  output logic      [PINS-1:0]     pad_rx_en_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [DATA_W-1:0]     route_low;
  logic [DATA_W-1:0]     route_high;
  logic [PINS-1:0]       latch;
  logic [PINS-1:0]       in_mode;
  logic [PINS-1:0]       out_mode;
  logic [PINS-1:0]       skip;
  logic [SPI_MODE_W-1:0] spi_mode;

  wire wr_low   = wr_i && addr_i == OFF_ROUTE_LOW;
  wire wr_high  = wr_i && addr_i == OFF_ROUTE_HIGH;
  wire wr_lat0  = wr_i && addr_i == OFF_LATCH0;
  wire wr_lat1  = wr_i && addr_i == OFF_LATCH1;
  wire wr_in0   = wr_i && addr_i == OFF_IN_MODE0;
  wire wr_in1   = wr_i && addr_i == OFF_IN_MODE1;
  wire wr_out0  = wr_i && addr_i == OFF_OUT_MODE0;
  wire wr_out1  = wr_i && addr_i == OFF_OUT_MODE1;
  wire wr_skip0 = wr_i && addr_i == OFF_SKIP0;
  wire wr_skip1 = wr_i && addr_i == OFF_SKIP1;
  wire wr_spi   = wr_i && addr_i == OFF_SPI_MODE;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      route_low  <= RST_ROUTE;
      route_high <= RST_ROUTE;
    end else if (ce_i) begin
      if (wr_low)
        route_low <= wdata_i & ROUTE_LOW_MASK;
      if (wr_high)
        route_high <= wdata_i & ROUTE_HIGH_MASK;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      in_mode  <= RST_IN_MODE;
      out_mode <= RST_OUT_MODE;
      skip     <= RST_SKIP;
      latch    <= RST_LATCH;
      spi_mode <= RST_SPI_MODE;
    end else if (ce_i) begin
      if (wr_in0)   in_mode[7:0]   <= wdata_i;
      if (wr_in1)   in_mode[15:8]  <= wdata_i;
      if (wr_out0)  out_mode[7:0]  <= wdata_i;
      if (wr_out1)  out_mode[15:8] <= wdata_i;
      if (wr_skip0) skip[7:0]      <= wdata_i;
      if (wr_skip1) skip[15:8]     <= wdata_i;
      if (wr_lat0)  latch[7:0]     <= wdata_i;
      if (wr_lat1)  latch[15:8]    <= wdata_i;
      if (wr_spi)   spi_mode       <= wdata_i[SPI_MODE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad input synchroniser

  logic [PINS-1:0] pad_meta;
  logic [PINS-1:0] pad_sync;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pad_meta <= '0;
      pad_sync <= '0;
    end else if (ce_i) begin
      pad_meta <= pad_in_i;
      pad_sync <= pad_meta;
    end
  end

  wire [PINS-1:0] pin_level = pad_sync & in_mode;

  ////////////////////////////////////////////////////////////////////////
  // Route enables

  wire xbar_en    = route_high[RH_XBAR_EN];
  wire pullup_dis = route_high[RH_PULLUP_DIS];
  wire four_wire  = |spi_mode;

  wire uart_en  = route_low[RL_UART];
  wire spi_en   = route_low[RL_SPI];
  wire smb_en   = route_low[RL_SMBUS];
  wire clk_en   = route_low[RL_SYSCLK];
  wire csync_en = route_low[RL_CMP_SYNC];
  wire casyn_en = route_low[RL_CMP_ASYNC];

  logic [NUM_SIG-1:0] sig_req;
  assign sig_req[SIG_UART_TX]   = xbar_en & uart_en;
  assign sig_req[SIG_UART_RX]   = xbar_en & uart_en;
  assign sig_req[SIG_SPI_SCK]   = xbar_en & spi_en;
  assign sig_req[SIG_SPI_MISO]  = xbar_en & spi_en;
  assign sig_req[SIG_SPI_MOSI]  = xbar_en & spi_en;
  assign sig_req[SIG_SPI_SEL]   = xbar_en & spi_en & four_wire;
  assign sig_req[SIG_SMB_SDA]   = xbar_en & smb_en;
  assign sig_req[SIG_SMB_SCL]   = xbar_en & smb_en;
  assign sig_req[SIG_CMP_SYNC]  = xbar_en & csync_en;
  assign sig_req[SIG_CMP_ASYNC] = xbar_en & casyn_en;
  assign sig_req[SIG_SYSCLK]    = xbar_en & clk_en;

  ////////////////////////////////////////////////////////////////////////
  // Priority claim chain

  logic [NUM_SIG-1:0][PINS-1:0]           grant;
  logic [NUM_SIG:FIRST_CHAINED][PINS-1:0] taken;
  logic [PINS-1:0]                        uart_pins;

  assign grant[SIG_UART_TX] =
    sig_req[SIG_UART_TX] ? PINS'(1) << PIN_UART_TX : '0;
  assign grant[SIG_UART_RX] =
    sig_req[SIG_UART_RX] ? PINS'(1) << PIN_UART_RX : '0;
  assign uart_pins = grant[SIG_UART_TX] | grant[SIG_UART_RX];

  assign taken[FIRST_CHAINED] = skip | uart_pins;

  genvar s;
  generate
    for (s = FIRST_CHAINED; s < NUM_SIG; s++) begin : g_claim
      pin_claim #(.WIDTH(PINS)) u_claim (
        .taken_i (taken[s]),
        .req_i   (sig_req[s]),
        .grant_o (grant[s]),
        .taken_o (taken[s+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Per-pin drive

  logic [PINS-1:0]    claimed;
  logic [PINS-1:0]    route_val;
  logic [PINS-1:0]    route_oe;
  logic [NUM_SIG-1:0] next_periph_in;

  always_comb begin
    claimed = '0;
    route_val = '0;
    route_oe = '0;
    next_periph_in = '0;
    for (int k = 0; k < NUM_SIG; k++) begin
      claimed = claimed | grant[k];
      route_val = route_val | (grant[k] & {PINS{periph_out_i[k]}});
      route_oe = route_oe | (grant[k] & {PINS{periph_oe_i[k]}});
      next_periph_in[k] = |(grant[k] & pin_level);
    end
  end

  wire [PINS-1:0] smb_pins = grant[SIG_SMB_SDA] | grant[SIG_SMB_SCL];
  wire [PINS-1:0] open_drain = ~out_mode | smb_pins;
  wire [PINS-1:0] drive_val = (claimed & route_val) | (~claimed & latch);
  wire [PINS-1:0] want_drive = (claimed & route_oe) | ~claimed;
  wire [PINS-1:0] active = {PINS{xbar_en}} & in_mode & want_drive;
  wire [PINS-1:0] drive_low = active & ~drive_val;

  wire [PINS-1:0] next_oe = active & (~open_drain | ~drive_val);
  wire [PINS-1:0] next_out = ~open_drain & drive_val;
  wire [PINS-1:0] next_pullup =
    in_mode & open_drain & ~drive_low & {PINS{~pullup_dis}};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pad_o        <= '0;
      pad_oe_o     <= '0;
      pad_pullup_o <= '0;
      pad_rx_en_o  <= '0;
      periph_in_o  <= '0;
    end else if (ce_i) begin
      pad_o        <= next_out;
      pad_oe_o     <= next_oe;
      pad_pullup_o <= next_pullup;
      pad_rx_en_o  <= in_mode;
      periph_in_o  <= next_periph_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    unique case (addr_i)
      OFF_ROUTE_LOW:  next_rdata = route_low;
      OFF_ROUTE_HIGH: next_rdata = route_high;
      OFF_LATCH0:     next_rdata = pin_level[7:0];
      OFF_LATCH1:     next_rdata = pin_level[15:8];
      OFF_IN_MODE0:   next_rdata = in_mode[7:0];
      OFF_IN_MODE1:   next_rdata = in_mode[15:8];
      OFF_OUT_MODE0:  next_rdata = out_mode[7:0];
      OFF_OUT_MODE1:  next_rdata = out_mode[15:8];
      OFF_SKIP0:      next_rdata = skip[7:0];
      OFF_SKIP1:      next_rdata = skip[15:8];
      OFF_SPI_MODE:   next_rdata = DATA_W'(spi_mode);
      default:        next_rdata = '0;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i)
      rdata_o <= '0;
    else if (ce_i)
      rdata_o <= rd_i ? next_rdata : '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  wire [PINS-1:0] chained = taken[NUM_SIG] & ~taken[FIRST_CHAINED];

  a_analog_quiet: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i |=> ((pad_oe_o | pad_pullup_o | pad_rx_en_o) & ~$past(in_mode))
      == '0)
    else $error("analog pin not quiet");
  a_xbar_off_idle: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && !xbar_en |=> pad_oe_o == '0)
    else $error("driver on while crossbar off");
  a_uart_tx_pin: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && xbar_en && uart_en && in_mode[PIN_UART_TX]
      && out_mode[PIN_UART_TX] && periph_oe_i[SIG_UART_TX]
    |=> pad_oe_o[PIN_UART_TX]
      && pad_o[PIN_UART_TX] == $past(periph_out_i[SIG_UART_TX]))
    else $error("uart transmit not on its pin");
  a_smbus_od: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i |=> ($past(smb_pins) & pad_o) == '0)
    else $error("smbus pin driven high");
  a_pullup_low: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (pad_oe_o & ~pad_o & pad_pullup_o) == '0)
    else $error("pullup on low-driven pin");
  a_pullup_dis: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && pullup_dis |=> pad_pullup_o == '0)
    else $error("pullup on while disabled");
  a_spi_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    xbar_en && spi_en && skip == '0 |->
      $countones(grant[SIG_SPI_SCK] | grant[SIG_SPI_MISO]
        | grant[SIG_SPI_MOSI] | grant[SIG_SPI_SEL])
      == (four_wire ? SPI_PINS_4W : SPI_PINS_3W))
    else $error("spi pin count wrong");
  a_skip_kept: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (chained & (skip | uart_pins)) == '0)
    else $error("skipped pin claimed");
  a_reserved_zero: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == OFF_ROUTE_LOW |=> rdata_o[7:6] == 2'h0)
    else $error("reserved route bits nonzero");
  a_pin_read: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && rd_i && addr_i == OFF_LATCH0 |=>
      rdata_o == $past(pin_level[7:0]))
    else $error("pin read not pad level");
endmodule
